//--- pcr_pkg.sv
// Package: offsets, reset values and carriers for the channel 5 config bank
package pcr_pkg;

  // ****************************************************************
  // Register offsets, page zero
  // ****************************************************************
  localparam logic [7:0] PAGE_ZERO        = 8'h00;
  localparam logic [7:0] OFF_CH5_INPUT    = 8'h50;
  localparam logic [7:0] OFF_CH5_VOLUME   = 8'h52;
  localparam logic [7:0] OFF_CH5_GAIN     = 8'h53;
  localparam logic [7:0] OFF_CH5_PHASE    = 8'h54;
  localparam logic [7:0] OFF_CH6_INPUT    = 8'h55;

  // ****************************************************************
  // Reset values and field layout
  // ****************************************************************
  localparam logic [7:0] RST_INPUT        = 8'h00;
  localparam logic [7:0] RST_VOLUME       = 8'hC9;
  localparam logic [7:0] RST_GAIN         = 8'h80;
  localparam logic [7:0] RST_PHASE        = 8'h00;
  localparam int         SRC_LSB          = 5;
  localparam int         SRC_MSB          = 6;
  localparam int         GAIN_LSB         = 4;
  localparam logic [7:0] MASK_INPUT       = 8'h60;
  localparam logic [7:0] MASK_GAIN        = 8'hF0;
  localparam logic [1:0] SRC_RESERVED     = 2'h3;
  localparam logic [7:0] VOL_MUTE         = 8'h00;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcr_req_t;

  typedef struct packed {
    logic [1:0] chan5_source_select;
    logic       chan5_source_valid;
    logic [7:0] chan5_volume_level;
    logic       chan5_mute;
    logic [3:0] chan5_gain_trim;
    logic [7:0] chan5_phase_delay;
    logic [1:0] chan6_source_select;
    logic       chan6_source_valid;
  } pcr_cfg_t;

endpackage

//--- pcr_regs.sv
// Channel 5 configuration registers plus channel 6 input configuration
`timescale 1ns/1ps
// What this block does
// - Channel 5 source codes 0-2 select PDM pair three; code 3 reserved
// - Volume code 0 mutes; code 1 is -100 dB, 0.5 dB per step
// - Channel 5 volume register at 0x52 resets to C9h, unity gain
// - Gain trim bits 7-4: code 0 is -0.8 dB, 0.1 dB per code
// - Gain trim register at 0x53 resets to 80h; low nibble reads zero
// - Phase field delays channel by that many modulator clock cycles
// - Phase register at 0x54 resets to zero
// - Channel 6 input register at 0x55 resets zero; only bits 6-5 writable
// - Channel 5 input register at 0x50, page zero, resets to zero
module pcr_regs (
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  input  wire pcr_pkg::pcr_req_t REQ_I,
  output logic [7:0]             RDATA_O,
  output logic                   RVALID_O,
  output pcr_pkg::pcr_cfg_t      CFG_O
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] ch5_input_ff;
  logic [7:0] ch5_volume_ff;
  logic [7:0] ch5_gain_ff;
  logic [7:0] ch5_phase_ff;
  logic [7:0] ch6_input_ff;
  logic       sel_page;
  logic       wr_hit;

  // Page other than zero leaves this bank untouched
  assign sel_page = (REQ_I.page == pcr_pkg::PAGE_ZERO);
  assign wr_hit   = REQ_I.wr && sel_page;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ch5_input_ff <= pcr_pkg::RST_INPUT;
    end else if (wr_hit && REQ_I.addr == pcr_pkg::OFF_CH5_INPUT) begin
      ch5_input_ff <= REQ_I.wdata & pcr_pkg::MASK_INPUT;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ch5_volume_ff <= pcr_pkg::RST_VOLUME;
    end else if (wr_hit && REQ_I.addr == pcr_pkg::OFF_CH5_VOLUME) begin
      ch5_volume_ff <= REQ_I.wdata;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ch5_gain_ff <= pcr_pkg::RST_GAIN;
    end else if (wr_hit && REQ_I.addr == pcr_pkg::OFF_CH5_GAIN) begin
      ch5_gain_ff <= REQ_I.wdata & pcr_pkg::MASK_GAIN;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ch5_phase_ff <= pcr_pkg::RST_PHASE;
    end else if (wr_hit && REQ_I.addr == pcr_pkg::OFF_CH5_PHASE) begin
      ch5_phase_ff <= REQ_I.wdata;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ch6_input_ff <= pcr_pkg::RST_INPUT;
    end else if (wr_hit && REQ_I.addr == pcr_pkg::OFF_CH6_INPUT) begin
      ch6_input_ff <= REQ_I.wdata & pcr_pkg::MASK_INPUT;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    if (sel_page) begin
      unique case (REQ_I.addr)
        pcr_pkg::OFF_CH5_INPUT:  nxt_rdata = ch5_input_ff;
        pcr_pkg::OFF_CH5_VOLUME: nxt_rdata = ch5_volume_ff;
        pcr_pkg::OFF_CH5_GAIN:   nxt_rdata = ch5_gain_ff;
        pcr_pkg::OFF_CH5_PHASE:  nxt_rdata = ch5_phase_ff;
        pcr_pkg::OFF_CH6_INPUT:  nxt_rdata = ch6_input_ff;
        // Unmapped offsets read zero
        default:                 nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RDATA_O  <= 8'h00;
      RVALID_O <= 1'b0;
    end else begin
      RVALID_O <= REQ_I.rd;
      if (REQ_I.rd) begin
        RDATA_O <= nxt_rdata;
      end
    end
  end

  // ****************************************************************
  // Datapath settings
  // ****************************************************************
  // Registered so the datapath sees settings one cycle after the write
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      CFG_O <= '0;
      CFG_O.chan5_source_valid <= 1'b1;
      CFG_O.chan5_volume_level <= pcr_pkg::RST_VOLUME;
      CFG_O.chan5_gain_trim    <= pcr_pkg::RST_GAIN[7:4];
      CFG_O.chan6_source_valid <= 1'b1;
    end else begin
      CFG_O.chan5_source_select <=
        ch5_input_ff[pcr_pkg::SRC_MSB:pcr_pkg::SRC_LSB];
      CFG_O.chan5_source_valid  <=
        ch5_input_ff[pcr_pkg::SRC_MSB:pcr_pkg::SRC_LSB]
        != pcr_pkg::SRC_RESERVED;
      CFG_O.chan5_volume_level  <= ch5_volume_ff;
      CFG_O.chan5_mute          <= ch5_volume_ff == pcr_pkg::VOL_MUTE;
      CFG_O.chan5_gain_trim     <= ch5_gain_ff[7:pcr_pkg::GAIN_LSB];
      CFG_O.chan5_phase_delay   <= ch5_phase_ff;
      CFG_O.chan6_source_select <=
        ch6_input_ff[pcr_pkg::SRC_MSB:pcr_pkg::SRC_LSB];
      CFG_O.chan6_source_valid  <=
        ch6_input_ff[pcr_pkg::SRC_MSB:pcr_pkg::SRC_LSB]
        != pcr_pkg::SRC_RESERVED;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_vol_reset;
    @(posedge CLK_I) RST_I |=> ch5_volume_ff == 8'hC9;
  endproperty
  a_vol_reset: assert property (p_vol_reset)
    else $error("volume reset value wrong");

  property p_gain_reset;
    @(posedge CLK_I) RST_I |=> ch5_gain_ff == 8'h80;
  endproperty
  a_gain_reset: assert property (p_gain_reset)
    else $error("gain trim reset value wrong");

  property p_phase_reset;
    @(posedge CLK_I) RST_I |=> ch5_phase_ff == 8'h00
      && ch5_input_ff == 8'h00;
  endproperty
  a_phase_reset: assert property (p_phase_reset)
    else $error("phase or input reset wrong");

  property p_reserved_zero;
    @(posedge CLK_I) disable iff (RST_I)
      ch5_gain_ff[3:0] == 4'h0 && ch5_input_ff[7] == 1'b0
      && ch5_input_ff[4:0] == 5'h00 && ch6_input_ff[7] == 1'b0
      && ch6_input_ff[4:0] == 5'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit set");

  property p_ch6_write;
    @(posedge CLK_I) disable iff (RST_I)
      wr_hit && REQ_I.addr == 8'h55
      |=> ch6_input_ff[6:5] == $past(REQ_I.wdata[6:5]);
  endproperty
  a_ch6_write: assert property (p_ch6_write)
    else $error("ch6 source write lost");

  property p_ch5_write;
    @(posedge CLK_I) disable iff (RST_I)
      wr_hit && REQ_I.addr == 8'h50
      |=> ch5_input_ff[6:5] == $past(REQ_I.wdata[6:5]);
  endproperty
  a_ch5_write: assert property (p_ch5_write)
    else $error("ch5 source write lost");

  property p_mute;
    @(posedge CLK_I) disable iff (RST_I)
      wr_hit && REQ_I.addr == 8'h52 && REQ_I.wdata == 8'h00
      |=> ##1 CFG_O.chan5_mute;
  endproperty
  a_mute: assert property (p_mute)
    else $error("mute not applied");

  property p_src_valid;
    @(posedge CLK_I) disable iff (RST_I)
      wr_hit && REQ_I.addr == 8'h50
      |=> ##1 CFG_O.chan5_source_valid == ($past(REQ_I.wdata[6:5], 2)
        != 2'h3);
  endproperty
  a_src_valid: assert property (p_src_valid)
    else $error("source validity wrong");

  property p_gain_out;
    @(posedge CLK_I) disable iff (RST_I)
      wr_hit && REQ_I.addr == 8'h53
      |=> ##1 CFG_O.chan5_gain_trim == $past(REQ_I.wdata[7:4], 2);
  endproperty
  a_gain_out: assert property (p_gain_out)
    else $error("gain trim not forwarded");

  property p_phase_out;
    @(posedge CLK_I) disable iff (RST_I)
      wr_hit && REQ_I.addr == 8'h54
      |=> ##1 CFG_O.chan5_phase_delay == $past(REQ_I.wdata, 2);
  endproperty
  a_phase_out: assert property (p_phase_out)
    else $error("phase delay not forwarded");

  // ****************************************************************
  // Read port and refusal checks
  // ****************************************************************
  // Every strobe answered exactly one cycle later
  property p_rd_valid;
    @(posedge CLK_I) disable iff (RST_I)
      REQ_I.rd |=> RVALID_O;
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read answer missing");

  // Read data holds until the next strobe
  property p_rd_idle;
    @(posedge CLK_I) disable iff (RST_I)
      !REQ_I.rd |=> !RVALID_O && $stable(RDATA_O);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read port moved without strobe");

  property p_rd_other_page;
    @(posedge CLK_I) disable iff (RST_I)
      REQ_I.rd && REQ_I.page != pcr_pkg::PAGE_ZERO
      |=> RDATA_O == 8'h00;
  endproperty
  a_rd_other_page: assert property (p_rd_other_page)
    else $error("other page read not zero");

  property p_rd_volume;
    @(posedge CLK_I) disable iff (RST_I)
      REQ_I.rd && sel_page && REQ_I.addr == pcr_pkg::OFF_CH5_VOLUME
      |=> RDATA_O == $past(ch5_volume_ff);
  endproperty
  a_rd_volume: assert property (p_rd_volume)
    else $error("volume read back wrong");

  property p_rd_gain;
    @(posedge CLK_I) disable iff (RST_I)
      REQ_I.rd && sel_page && REQ_I.addr == pcr_pkg::OFF_CH5_GAIN
      |=> RDATA_O[3:0] == 4'h0
        && RDATA_O[7:4] == $past(ch5_gain_ff[7:4]);
  endproperty
  a_rd_gain: assert property (p_rd_gain)
    else $error("gain trim read back wrong");

  // A page decode slip would corrupt live settings
  property p_page_refuse;
    @(posedge CLK_I) disable iff (RST_I)
      REQ_I.wr && !sel_page
      |=> $stable(ch5_input_ff) && $stable(ch5_volume_ff)
        && $stable(ch5_gain_ff) && $stable(ch5_phase_ff)
        && $stable(ch6_input_ff);
  endproperty
  a_page_refuse: assert property (p_page_refuse)
    else $error("other page write landed");

  property p_unmapped_refuse;
    @(posedge CLK_I) disable iff (RST_I)
      wr_hit && REQ_I.addr == 8'h51
      |=> $stable(ch5_input_ff) && $stable(ch5_volume_ff)
        && $stable(ch5_gain_ff) && $stable(ch5_phase_ff)
        && $stable(ch6_input_ff);
  endproperty
  a_unmapped_refuse: assert property (p_unmapped_refuse)
    else $error("unmapped write landed");

  // Datapath settings follow a write after two edges
  property p_vol_out;
    @(posedge CLK_I) disable iff (RST_I)
      wr_hit && REQ_I.addr == pcr_pkg::OFF_CH5_VOLUME
      |=> ##1 CFG_O.chan5_volume_level == $past(REQ_I.wdata, 2);
  endproperty
  a_vol_out: assert property (p_vol_out)
    else $error("volume not forwarded");

  property p_unmute;
    @(posedge CLK_I) disable iff (RST_I)
      wr_hit && REQ_I.addr == pcr_pkg::OFF_CH5_VOLUME && REQ_I.wdata != 8'h00
      |=> ##1 !CFG_O.chan5_mute;
  endproperty
  a_unmute: assert property (p_unmute)
    else $error("mute held at nonzero volume");

  property p_ch6_valid;
    @(posedge CLK_I) disable iff (RST_I)
      wr_hit && REQ_I.addr == pcr_pkg::OFF_CH6_INPUT
      |=> ##1 CFG_O.chan6_source_valid == ($past(REQ_I.wdata[6:5], 2)
        != 2'h3);
  endproperty
  a_ch6_valid: assert property (p_ch6_valid)
    else $error("ch6 source validity wrong");

  property p_cfg_reset;
    @(posedge CLK_I) RST_I
      |=> CFG_O.chan5_volume_level == pcr_pkg::RST_VOLUME
        && CFG_O.chan5_gain_trim == 4'h8
        && CFG_O.chan5_phase_delay == 8'h00
        && !CFG_O.chan5_mute;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("datapath settings reset wrong");

endmodule

//--- pcr_regs_tb_top.sv
// Self-checking testbench for the channel 5 config register bank
`timescale 1ns/1ps
module pcr_regs_tb_top;
  // ****************************************************************
  // Signals and instance
  // ****************************************************************
  logic              clk;
  logic              rst;
  pcr_pkg::pcr_req_t req;
  logic [7:0]        rdata;
  logic              rvalid;
  pcr_pkg::pcr_cfg_t cfg;
  pcr_pkg::pcr_cfg_t exp_cfg;
  int                miscompares;
  int                n_checks;

  pcr_regs i_pcr_regs (
    .CLK_I    (clk),
    .RST_I    (rst),
    .REQ_I    (req),
    .RDATA_O  (rdata),
    .RVALID_O (rvalid),
    .CFG_O    (cfg)
  );

  initial clk = 1'b0;
  always #25 clk = ~clk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic fail(input string what);
    miscompares++;
    $display("mismatch at %0t: %s", $time, what);
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
    n_checks++;
    if (got !== exp) fail(what);
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) fail(what);
  endtask

  task automatic chk_cfg(input string what);
    n_checks++;
    if (cfg !== exp_cfg) fail(what);
  endtask

  // Write, then one more cycle so the config outputs have settled
  task automatic wr(input logic [7:0] pg, input logic [7:0] ad,
                    input logic [7:0] d);
    @(negedge clk);
    req = '{wr:1'b1, rd:1'b0, page:pg, addr:ad, wdata:d};
    @(negedge clk);
    req = '0;
    @(negedge clk);
  endtask

  // Answer stands one cycle only, so it is sampled in that cycle
  task automatic rd(input logic [7:0] pg, input logic [7:0] ad,
                    input logic [7:0] exp, input string what);
    @(negedge clk);
    req = '{wr:1'b0, rd:1'b1, page:pg, addr:ad, wdata:8'h00};
    @(negedge clk);
    req = '0;
    chk1(rvalid, 1'b1, what);
    chk8(rdata, exp, what);
  endtask

  task automatic do_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    exp_cfg = '0;
    exp_cfg.chan5_volume_level = 8'hC9;
    exp_cfg.chan5_gain_trim = 4'h8;
    exp_cfg.chan5_source_valid = 1'b1;
    exp_cfg.chan6_source_valid = 1'b1;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    chk1(rvalid, 1'b0, "idle valid");
    chk_cfg("reset cfg");
    rd(8'h00, 8'h50, 8'h00, "ch5 input rst");
    rd(8'h00, 8'h52, 8'hC9, "volume rst");
    rd(8'h00, 8'h53, 8'h80, "gain rst");
    rd(8'h00, 8'h54, 8'h00, "phase rst");
    rd(8'h00, 8'h55, 8'h00, "ch6 input rst");
    $display("test reset done");
  endtask

  task automatic t_fields;
    logic [7:0] v [4] = '{8'h00, 8'h01, 8'hC9, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 8'h52, v[i]);
      exp_cfg.chan5_volume_level = v[i];
      exp_cfg.chan5_mute = (v[i] == 8'h00);
      chk_cfg("volume cfg");
      rd(8'h00, 8'h52, v[i], "volume rb");
    end
    wr(8'h00, 8'h53, 8'hFF);
    exp_cfg.chan5_gain_trim = 4'hF;
    chk_cfg("gain cfg");
    rd(8'h00, 8'h53, 8'hF0, "gain rb");
    wr(8'h00, 8'h54, 8'hFF);
    exp_cfg.chan5_phase_delay = 8'hFF;
    chk_cfg("phase cfg");
    @(negedge clk);
    req = '{wr:1'b1, rd:1'b1, page:8'h00, addr:8'h54, wdata:8'h00};
    @(negedge clk);
    req = '0;
    chk8(rdata, 8'hFF, "old value on same-cycle read");
    exp_cfg.chan5_phase_delay = 8'h00;
    rd(8'h00, 8'h54, 8'h00, "phase rb");
    chk_cfg("phase cleared cfg");
    $display("test fields done");
  endtask

  task automatic t_source;
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, 8'h50, {1'b1, c[1:0], 5'h1F});
      wr(8'h00, 8'h55, {1'b1, ~c[1:0], 5'h1F});
      exp_cfg.chan5_source_select = c[1:0];
      exp_cfg.chan5_source_valid = (c != 3);
      exp_cfg.chan6_source_select = ~c[1:0];
      exp_cfg.chan6_source_valid = (c != 0);
      chk_cfg("source cfg");
      rd(8'h00, 8'h50, {1'b0, c[1:0], 5'h00}, "ch5 src");
      rd(8'h00, 8'h55, {1'b0, ~c[1:0], 5'h00}, "ch6 src");
    end
    $display("test source done");
  endtask

  task automatic t_refuse;
    wr(8'h01, 8'h52, 8'h11);
    wr(8'h00, 8'h51, 8'h22);
    chk_cfg("refused writes");
    rd(8'h00, 8'h52, 8'hFF, "other page write");
    rd(8'h00, 8'h51, 8'h00, "unmapped read");
    rd(8'h01, 8'h52, 8'h00, "other page read");
    $display("test refuse done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watchdog cuts a hang short
  initial begin
    #1000000;
    fail("watchdog");
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    req = '0;
    exp_cfg = '0;
    miscompares = 0;
    n_checks = 0;
    do_reset();
    t_reset();
    t_fields();
    t_source();
    t_refuse();
    do_reset();
    t_reset();
    print_verdict();
  end
endmodule
